// *** common/ubrg_pkg.sv ***
// constants and types shared by the baud rate generator files
// Function
// - base clock source comes from divider control bits 7 and 6
// - base clock reaches the counters only while unit power is on
// - base clock output stays low while unit power is off
// - transmit counter held at zero unless power and transmit enable set
// - transmit counter runs while power and transmit enable are both set
// - first transmit data write clears the transmit counter
// - receive counter held at zero unless power and receive enable set
// - receive counter counts only after a falling edge is seen on the serial line
// - receive counter halts after a frame until the next start bit
// - divide value k from divider control bits 4..0, legal 8..31
// - bit rate equals base clock over two times k
// - separate five-bit counters for transmit and receive paths
// - falling edge starts receive count, low after k counts is start
package ubrg_pkg;

    typedef logic [4:0] ubrg_cnt_t;
    typedef logic [7:0] ubrg_byte_t;

    typedef enum logic [1:0] {
        UBRG_SRC_TIMER = 2'h0,
        UBRG_SRC_DIV2  = 2'h1,
        UBRG_SRC_DIV8  = 2'h2,
        UBRG_SRC_DIV32 = 2'h3
    } ubrg_src_e;

    // gray order along idle, verify, active
    typedef enum logic [1:0] {
        UBRG_RX_IDLE   = 2'h0,
        UBRG_RX_VERIFY = 2'h1,
        UBRG_RX_ACTIVE = 2'h3
    } ubrg_rx_e;

    // register byte addresses
    localparam logic [7:0] UBRG_ADDR_DIVIDER = 8'h00;
    localparam logic [7:0] UBRG_ADDR_MODE    = 8'h04;
    localparam logic [7:0] UBRG_ADDR_STATUS  = 8'h08;
    localparam logic [7:0] UBRG_ADDR_TXDATA  = 8'h0C;

    // field positions
    localparam int UBRG_SRC_MSB   = 7;
    localparam int UBRG_SRC_LSB   = 6;
    localparam int UBRG_DIV_MSB   = 4;
    localparam int UBRG_POWER_BIT = 7;
    localparam int UBRG_TXE_BIT   = 6;
    localparam int UBRG_RXE_BIT   = 5;
    localparam int UBRG_ST_RXCNT  = 8;
    localparam int UBRG_ST_TXPH   = 16;
    localparam int UBRG_ST_RXPH   = 17;
    localparam int UBRG_ST_RXST   = 18;
    localparam int UBRG_ST_TXIDLE = 20;

    // values after reset
    localparam ubrg_byte_t UBRG_DIVIDER_RESET = 8'h48;
    localparam ubrg_byte_t UBRG_MODE_RESET    = 8'h00;
    localparam ubrg_cnt_t  UBRG_CNT_ZERO      = 5'h00;
    localparam ubrg_cnt_t  UBRG_K_MIN         = 5'h08;

    // prescaler terminal counts
    localparam logic [0:0] UBRG_PRE2_END  = 1'h1;
    localparam logic [2:0] UBRG_PRE8_END  = 3'h7;
    localparam ubrg_cnt_t  UBRG_PRE32_END = 5'h1F;

    localparam logic [1:0] UBRG_HTRANS_NONSEQ = 2'h2;
    localparam logic       UBRG_HRESP_OKAY    = 1'h0;

    // k below the legal floor runs as the floor
    function automatic ubrg_cnt_t ubrg_clamp_k(input ubrg_cnt_t k);
        ubrg_clamp_k = (k < UBRG_K_MIN) ? UBRG_K_MIN : k;
    endfunction : ubrg_clamp_k

endpackage : ubrg_pkg

// *** core/ubrg_counter.sv ***
// five-bit divide counter with serial clock phase
`timescale 1ns/1ps
module ubrg_counter (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // control
    input  wire logic             run,
    input  wire logic             clear,
    input  wire logic             base_tick,
    input  wire ubrg_pkg::ubrg_cnt_t k_value,
    // state
    output ubrg_pkg::ubrg_cnt_t   count,
    output logic                  phase,
    output logic                  half_tick
);
    import ubrg_pkg::*;

    ubrg_cnt_t count_reg;
    ubrg_cnt_t count_next;
    logic      phase_reg;
    logic      half_reg;
    logic      at_end;

    assign at_end = (count_reg == k_value - 5'h01);

    always_comb begin
        count_next = count_reg;
        if (!run || clear) begin
            count_next = UBRG_CNT_ZERO;
        end else if (base_tick) begin
            count_next = at_end ? UBRG_CNT_ZERO : count_reg + 5'h01;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            count_reg <= UBRG_CNT_ZERO;
        end else begin
            count_reg <= count_next;
        end
    end

    // phase toggles every k ticks, so one bit lasts 2k ticks
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            phase_reg <= 1'b0;
            half_reg  <= 1'b0;
        end else if (!run || clear) begin
            phase_reg <= 1'b0;
            half_reg  <= 1'b0;
        end else begin
            half_reg <= base_tick && at_end;
            if (base_tick && at_end) begin
                phase_reg <= ~phase_reg;
            end
        end
    end

    assign count     = count_reg;
    assign phase     = phase_reg;
    assign half_tick = half_reg;

endmodule : ubrg_counter

// *** core/ubrg_top.sv ***
// baud rate generator: bus slave, source select and both counters
//
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module ubrg_top (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                reset,
    // ahb-lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic [31:0]              hrdata,
    output logic                     hresp,
    // clock sources
    input  wire logic                eight_bit_timer_output,
    // serial line
    input  wire logic                serial_input_line,
    // shift logic status
    input  wire logic                tx_shift_idle,
    input  wire logic                rx_frame_done,
    // base clock out
    output logic                     selected_base_clock,
    // transmit side
    output ubrg_pkg::ubrg_byte_t     transmit_shift_register,
    output logic                     tx_load,
    output logic                     tx_serial_clock,
    output logic                     tx_bit_edge,
    // receive side
    output logic                     rx_serial_clock,
    output logic                     rx_bit_edge,
    output logic                     rx_start_valid,
    output logic                     rx_active
);
    import ubrg_pkg::*;

    // bus pipeline
    logic        dp_write_reg;
    logic [7:0]  dp_addr_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        addr_phase;
    logic        wr_go;

    // software visible state
    ubrg_byte_t  baud_divider_control_reg;
    ubrg_byte_t  serial_mode_register_reg;
    ubrg_byte_t  tx_data_reg;
    logic        tx_load_reg;
    logic        tx_clear_reg;

    // decoded controls
    logic        unit_power_on;
    logic        transmit_enable_bit;
    logic        receive_enable_bit;
    logic        clock_source_select_hi;
    logic        clock_source_select_lo;
    ubrg_src_e   src_sel;
    ubrg_cnt_t   divide_value_field;
    ubrg_cnt_t   k_value;
    logic        tx_run;
    logic        rx_run;

    // base clock generation
    ubrg_cnt_t   presc_reg;
    logic        timer_prev_reg;
    logic        src_tick;
    logic        base_tick_reg;

    // receive start detection
    logic        line_prev_reg;
    logic        line_fall;
    ubrg_rx_e    rx_state_reg;
    ubrg_rx_e    rx_state_next;
    logic        rx_start_reg;

    // counter outputs
    ubrg_cnt_t   tx_count;
    logic        tx_phase;
    logic        tx_half;
    ubrg_cnt_t   rx_count;
    logic        rx_phase;
    logic        rx_half;
    logic        rx_cnt_run;


    // bus slave: never waits, always answers okay

    assign hreadyout = 1'b1;
    assign hresp     = UBRG_HRESP_OKAY;
    assign hrdata    = rdata_reg;

    assign addr_phase = hsel && hready && htrans[1];
    assign wr_go      = dp_write_reg && hready;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dp_write_reg <= 1'b0;
            dp_addr_reg  <= 8'h00;
        end else if (hready) begin
            dp_write_reg <= addr_phase && hwrite;
            dp_addr_reg  <= haddr[7:0];
        end
    end

    // read data is fetched in the address phase so it stands registered
    // through the whole data phase
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (haddr[7:0])
            UBRG_ADDR_DIVIDER: rdata_next[7:0] = baud_divider_control_reg;
            UBRG_ADDR_MODE:    rdata_next[7:0] = serial_mode_register_reg;
            UBRG_ADDR_STATUS: begin
                rdata_next[4:0]                     = tx_count;
                rdata_next[UBRG_ST_RXCNT +: 5]      = rx_count;
                rdata_next[UBRG_ST_TXPH]            = tx_phase;
                rdata_next[UBRG_ST_RXPH]            = rx_phase;
                rdata_next[UBRG_ST_RXST +: 2]       = rx_state_reg;
                rdata_next[UBRG_ST_TXIDLE]          = tx_shift_idle;
            end
            UBRG_ADDR_TXDATA:  rdata_next[7:0] = tx_data_reg;
            default:           rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata_reg <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            rdata_reg <= rdata_next;
        end
    end


    // registers written by software

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            baud_divider_control_reg <= UBRG_DIVIDER_RESET;
        end else if (wr_go && dp_addr_reg == UBRG_ADDR_DIVIDER) begin
            baud_divider_control_reg <= hwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            serial_mode_register_reg <= UBRG_MODE_RESET;
        end else if (wr_go && dp_addr_reg == UBRG_ADDR_MODE) begin
            serial_mode_register_reg <= hwdata[7:0];
        end
    end

    // a write to the transmit data word while power and transmit enable are set hands the byte to the shifter;
    // while the shifter is idle it is the first byte of a run
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tx_data_reg  <= 8'h00;
            tx_load_reg  <= 1'b0;
            tx_clear_reg <= 1'b0;
        end else begin
            tx_load_reg  <= 1'b0;
            tx_clear_reg <= 1'b0;
            if (wr_go && dp_addr_reg == UBRG_ADDR_TXDATA && tx_run) begin
                tx_data_reg  <= hwdata[7:0];
                tx_load_reg  <= 1'b1;
                tx_clear_reg <= tx_shift_idle;
            end
        end
    end


    // field decode

    assign unit_power_on       = serial_mode_register_reg[UBRG_POWER_BIT];
    assign transmit_enable_bit = serial_mode_register_reg[UBRG_TXE_BIT];
    assign receive_enable_bit  = serial_mode_register_reg[UBRG_RXE_BIT];

    assign clock_source_select_hi = baud_divider_control_reg[UBRG_SRC_MSB];
    assign clock_source_select_lo = baud_divider_control_reg[UBRG_SRC_LSB];
    assign src_sel = ubrg_src_e'({clock_source_select_hi,
                                  clock_source_select_lo});

    assign divide_value_field = baud_divider_control_reg[UBRG_DIV_MSB:0];
    // values under eight are not legal; run them as eight
    assign k_value = ubrg_clamp_k(divide_value_field);

    assign tx_run = unit_power_on && transmit_enable_bit;
    assign rx_run = unit_power_on && receive_enable_bit;


    // prescaler and source select

    // the prescaler runs free on the peripheral clock so the divided
    // sources keep their phase across power changes
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            presc_reg <= UBRG_CNT_ZERO;
        end else begin
            presc_reg <= presc_reg + 5'h01;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            timer_prev_reg <= 1'b0;
        end else begin
            timer_prev_reg <= eight_bit_timer_output;
        end
    end

    // one tick per source period; the timer counts on its rising edge
    always_comb begin
        unique case (src_sel)
            UBRG_SRC_TIMER: src_tick = eight_bit_timer_output
                                       && !timer_prev_reg;
            UBRG_SRC_DIV2:  src_tick = (presc_reg[0:0] == UBRG_PRE2_END);
            UBRG_SRC_DIV8:  src_tick = (presc_reg[2:0] == UBRG_PRE8_END);
            UBRG_SRC_DIV32: src_tick = (presc_reg == UBRG_PRE32_END);
        endcase
    end

    // gated base clock; low for as long as the unit is powered down
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            base_tick_reg <= 1'b0;
        end else begin
            base_tick_reg <= src_tick && unit_power_on;
        end
    end

    assign selected_base_clock = base_tick_reg;


    // transmit counter

    ubrg_counter u_tx_counter (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .run       (tx_run),
        .clear     (tx_clear_reg),
        .base_tick (base_tick_reg),
        .k_value   (k_value),
        .count     (tx_count),
        .phase     (tx_phase),
        .half_tick (tx_half)
    );


    // receive start detection

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            line_prev_reg <= 1'b1;
        end else begin
            line_prev_reg <= serial_input_line;
        end
    end

    assign line_fall = line_prev_reg && !serial_input_line;

    always_comb begin
        rx_state_next = rx_state_reg;
        unique case (rx_state_reg)
            UBRG_RX_IDLE: begin
                if (line_fall) begin
                    rx_state_next = UBRG_RX_VERIFY;
                end
            end
            UBRG_RX_VERIFY: begin
                // after k counts the line is looked at again
                if (rx_half) begin
                    rx_state_next = serial_input_line ? UBRG_RX_IDLE
                                                      : UBRG_RX_ACTIVE;
                end
            end
            UBRG_RX_ACTIVE: begin
                if (rx_frame_done) begin
                    rx_state_next = UBRG_RX_IDLE;
                end
            end
            default: rx_state_next = UBRG_RX_IDLE;
        endcase
        if (!rx_run) begin
            rx_state_next = UBRG_RX_IDLE;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rx_state_reg <= UBRG_RX_IDLE;
        end else begin
            rx_state_reg <= rx_state_next;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rx_start_reg <= 1'b0;
        end else begin
            rx_start_reg <= rx_state_reg == UBRG_RX_VERIFY
                            && rx_state_next == UBRG_RX_ACTIVE;
        end
    end

    // counting stops in idle, so a glitch that fails the second look
    // leaves the counter cleared for the next edge
    assign rx_cnt_run = rx_run
                        && rx_state_reg != UBRG_RX_IDLE;


    // receive counter

    ubrg_counter u_rx_counter (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .run       (rx_cnt_run),
        .clear     (1'b0),
        .base_tick (base_tick_reg),
        .k_value   (k_value),
        .count     (rx_count),
        .phase     (rx_phase),
        .half_tick (rx_half)
    );


    // outputs to the shift logic

    assign transmit_shift_register = tx_data_reg;
    assign tx_load                 = tx_load_reg;
    assign tx_serial_clock         = tx_phase;
    assign tx_bit_edge             = tx_half;

    assign rx_serial_clock = rx_phase;
    // edges in the verify state belong to the start check, not to data
    assign rx_bit_edge     = rx_half && rx_state_reg == UBRG_RX_ACTIVE;
    assign rx_start_valid  = rx_start_reg;
    assign rx_active       = rx_state_reg == UBRG_RX_ACTIVE;

endmodule : ubrg_top

// *** verification/ubrg_assertions.sv ***
// port checker for the baud rate generator, bound to its top module
`timescale 1ns/1ps
module ubrg_checker
    import ubrg_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        reset,
    // register bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    // serial and shift logic
    input wire logic        serial_input_line,
    input wire logic        tx_shift_idle,
    input wire logic        rx_frame_done,
    // generator outputs
    input wire logic        selected_base_clock,
    input wire logic        tx_load,
    input wire logic        tx_bit_edge,
    input wire logic        rx_bit_edge,
    input wire logic        rx_start_valid,
    input wire logic        rx_active
);
    logic       wp, wd, ok, tv;
    logic [7:0] wa, dv, md, gap, nt;
    logic [4:0] k;
    wire        pw  = md[UBRG_POWER_BIT];
    wire        te  = pw & md[UBRG_TXE_BIT];
    wire        re  = pw & md[UBRG_RXE_BIT];
    wire  [1:0] src = dv[7:6];
    // shadow of the control registers, rebuilt from bus writes
    assign k = (dv[4:0] < 5'h08) ? 5'h08 : dv[4:0];
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wp <= 1'b0;
            wd <= 1'b0;
            wa <= 8'h00;
            dv <= UBRG_DIVIDER_RESET;
            md <= UBRG_MODE_RESET;
        end else begin
            wp <= hsel & hready & htrans[1] & hwrite;
            wd <= wp;
            wa <= haddr[7:0];
            if (wp && wa == UBRG_ADDR_DIVIDER) dv <= hwdata[7:0];
            if (wp && wa == UBRG_ADDR_MODE) md <= hwdata[7:0];
        end
    end
    // a tick spacing is trusted only two cycles past any config change
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            gap <= 8'h00;
            ok <= 1'b0;
        end else begin
            gap <= selected_base_clock ? 8'h00 : gap + 8'h01;
            ok <= (wp | wd | !pw) ? 1'b0 : (ok | selected_base_clock);
        end
    end
    // base ticks between transmit phase flips
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            nt <= 8'h00;
            tv <= 1'b0;
        end else begin
            nt <= (tx_bit_edge | tx_load) ? 8'h00 : nt + 8'(selected_base_clock);
            tv <= (wp | !te | tx_load) ? 1'b0 : (tv | tx_bit_edge);
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    a_base_gap: assert property (selected_base_clock && ok && src != 2'h0
        |-> gap == ((src == 2'h1) ? 8'h01 : (src == 2'h2) ? 8'h07 : 8'h1F))
        else $error("base tick spacing wrong");
    a_base_off: assert property (!pw && !$past(pw) |-> !selected_base_clock)
        else $error("base clock active while power off");
    a_tx_period: assert property (tx_bit_edge && tv
        |-> nt + 8'(selected_base_clock) == {3'h0, k})
        else $error("transmit half period not k ticks");
    a_tx_held: assert property (!te && !$past(te) |-> !tx_bit_edge && !tx_load)
        else $error("transmit side active while disabled");
    a_rx_quiet: assert property (rx_bit_edge |-> rx_active)
        else $error("receive edge outside a frame");
    a_rx_off: assert property (!re ##1 !re |-> !rx_active && !rx_bit_edge)
        else $error("receive side active while disabled");
    a_rx_start: assert property (rx_start_valid
        |-> rx_active && !$past(serial_input_line))
        else $error("start accepted on a high line");
    a_rx_halt: assert property (rx_frame_done |-> ##2 !rx_active [*4])
        else $error("receive count kept running after frame");
    c_tx_run: cover property (tx_bit_edge && tv);
    c_rx_start: cover property (rx_start_valid);
    c_rx_frame: cover property (rx_frame_done);
endmodule : ubrg_checker

bind ubrg_top ubrg_checker u_chk (.*);

// *** verification/ubrg_shift_model.sv ***
// stand-in for the transmit and receive shift logic
`timescale 1ns/1ps
module ubrg_shift_model #(
    parameter int TX_HALVES = 20,
    parameter int RX_HALVES = 18
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // from the generator
    input  wire logic tx_load,
    input  wire logic tx_bit_edge,
    input  wire logic rx_bit_edge,
    input  wire logic rx_active,
    // to the generator
    output logic      tx_shift_idle,
    output logic      rx_frame_done
);
    int tn, rn;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tx_shift_idle <= 1'b1;
            tn <= 0;
        end else if (tx_load) begin
            tx_shift_idle <= 1'b0;
            tn <= 0;
        end else if (!tx_shift_idle && tx_bit_edge) begin
            tn <= tn + 1;
            if (tn == TX_HALVES - 1) tx_shift_idle <= 1'b1;
        end
    end
    // an aborted frame restarts the bit count
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rn <= 0;
            rx_frame_done <= 1'b0;
        end else begin
            rx_frame_done <= rx_bit_edge && rn == RX_HALVES - 1;
            if (!rx_active || (rx_bit_edge && rn == RX_HALVES - 1)) rn <= 0;
            else if (rx_bit_edge) rn <= rn + 1;
        end
    end
endmodule : ubrg_shift_model

// *** verification/tb.sv ***
// self-checking bench for the baud rate generator
`timescale 1ns/1ps
module tb;
    import ubrg_pkg::*;
    logic        clk_sys, reset, hsel, hwrite, tmr, tmr_run, rxd, rdp;
    logic [31:0] haddr, hwdata, eq[$], mq[$];
    logic [1:0]  htrans;
    wire  [31:0] hrdata;
    wire  [7:0]  tsr;
    wire         hready, sbc, tx_load, tx_edge, rx_edge, rx_sv, rx_act;
    wire         tx_idle, rx_done;
    int          err_total, cmp_count, sbc_n, load_n, tmr_c, cyc, last;
    int          pq[$];
    int          dt[4] = '{6, 2, 8, 32};

    ubrg_top DUT (
        .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(),
        .eight_bit_timer_output(tmr), .serial_input_line(rxd),
        .tx_shift_idle(tx_idle), .rx_frame_done(rx_done),
        .selected_base_clock(sbc), .transmit_shift_register(tsr),
        .tx_load(tx_load), .tx_serial_clock(), .tx_bit_edge(tx_edge),
        .rx_serial_clock(), .rx_bit_edge(rx_edge), .rx_start_valid(rx_sv),
        .rx_active(rx_act)
    );
    ubrg_shift_model u_shift (
        .clk_sys(clk_sys), .reset(reset), .tx_load(tx_load),
        .tx_bit_edge(tx_edge), .rx_bit_edge(rx_edge), .rx_active(rx_act),
        .tx_shift_idle(tx_idle), .rx_frame_done(rx_done)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // timer runs at fifty percent duty, rising edge every six cycles
    always @(posedge clk_sys) begin
        tmr_c <= (tmr_c == 2) ? 0 : tmr_c + 1;
        if (tmr_run && tmr_c == 2) tmr <= ~tmr;
    end
    // result watcher: read data and transmit half periods
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        sbc_n <= sbc_n + int'(sbc);
        load_n <= load_n + int'(tx_load);
        if (rdp && hready === 1'b1) cmp(hrdata & mq.pop_front(), eq.pop_front());
        if (tx_edge === 1'b1) begin
            if (pq.size() > 0) cmp(32'(cyc - last), 32'(pq.pop_front()));
            last <= cyc;
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic test_done(input int bad);
        err_total += bad;
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    // s: 0 transmit edge, 1 start accepted, 2 frame done
    task automatic wev(input int s);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while ((s == 0 ? tx_edge : s == 1 ? rx_sv : rx_done) !== 1'b1
                   && n < 9000);
        if (n >= 9000) test_done(1);
    endtask : wev
    task automatic hwait();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (n >= 50) test_done(1);
    endtask : hwait
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= UBRG_HTRANS_NONSEQ;
        hwrite <= w;
        hwait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdp <= ~w;
        hwait();
        rdp <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        eq.push_back(e & m);
        mq.push_back(m);
        bus(a, 1'b0, 32'h0);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, {24'h0, d});
    endtask : wr

    initial begin
        int k, kk, seed;
        logic [7:0] b;
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        {tmr, tmr_run, rxd, rdp} = 4'h6;
        {tmr_c, cyc, last, sbc_n, load_n, err_total, cmp_count} = '0;
        seed = $urandom(83326);
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        rd(UBRG_ADDR_DIVIDER, 32'h48, 32'hFFFF_FFFF);
        rd(UBRG_ADDR_MODE, 32'h0, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0, 32'hFFFF_FFFF);
        cmp(32'(sbc_n), 32'h0);
        // every source; random k on the first three, a k below the legal floor on divide by 32
        for (int s = 0; s < 4; s++) begin
            k = (s == 3) ? 3 : 8 + $urandom % 24;
            kk = (k < 8) ? 8 : k;
            wr(UBRG_ADDR_MODE, 8'h80);
            wr(UBRG_ADDR_DIVIDER, {2'(s), 1'b0, 5'(k)});
            wr(UBRG_ADDR_MODE, 8'hC0);
            wev(0);
            @(negedge clk_sys);
            pq.push_back(kk * dt[s]);
            wev(0);
            @(negedge clk_sys);
        end
        // frozen timer source makes the transmit count deterministic
        wr(UBRG_ADDR_DIVIDER, 8'h1F);
        repeat (60) @(posedge clk_sys);
        tmr_run <= 1'b0;
        b = 8'($urandom);
        wr(UBRG_ADDR_TXDATA, b);
        rd(UBRG_ADDR_STATUS, 32'h0, 32'h0011_001F);
        rd(UBRG_ADDR_TXDATA, {24'h0, b}, 32'hFF);
        cmp({24'h0, tsr}, {24'h0, b});
        wr(UBRG_ADDR_MODE, 8'h80);
        wr(UBRG_ADDR_TXDATA, ~b);
        rd(UBRG_ADDR_STATUS, 32'h0, 32'h1F);
        cmp(32'(load_n), 32'h1);
        wr(UBRG_ADDR_MODE, 8'h40);
        tmr_run <= 1'b1;
        repeat (3) @(posedge clk_sys);
        kk = sbc_n;
        repeat (40) @(posedge clk_sys);
        cmp(32'(sbc_n - kk), 32'h0);
        rd(UBRG_ADDR_STATUS, 32'h0, 32'h1F);
        // receive: short glitch, one whole frame, one aborted frame
        wr(UBRG_ADDR_DIVIDER, 8'h48);
        wr(UBRG_ADDR_MODE, 8'hA0);
        rxd <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rxd <= 1'b1;
        repeat (40) @(posedge clk_sys);
        rd(UBRG_ADDR_STATUS, 32'h0, 32'h000C_1F00);
        for (int f = 0; f < 2; f++) begin
            rxd <= 1'b0;
            wev(1);
            rd(UBRG_ADDR_STATUS, 32'h000C_0000, 32'h000C_0000);
            rxd <= 1'b1;
            if (f == 0) begin
                wev(2);
                repeat (20) @(posedge clk_sys);
                rd(UBRG_ADDR_STATUS, 32'h0, 32'h000C_0000);
            end else begin
                wr(UBRG_ADDR_MODE, 8'h80);
                rd(UBRG_ADDR_STATUS, 32'h0, 32'h000C_1F00);
            end
        end
        test_done(0);
    end
endmodule : tb
